// >>> verilog/icdt_pkg.sv
// package: register map, field layout and modes of the capture channel
package icdt_pkg;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_FIFO_READ = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // control one fields
  localparam int HALT_IDLE_BIT = 13;
  localparam int TSEL_LSB = 10;
  localparam int CPI_LSB = 5;
  localparam int OVR_BIT = 4;
  localparam int BNE_BIT = 3;
  localparam int MODE_LSB = 0;
  // control two fields
  localparam int CASCADE_BIT = 8;
  localparam int TRIG_SEL_BIT = 7;
  localparam int TRIG_RUN_BIT = 6;
  localparam int SYNC_LSB = 0;
  localparam logic [4:0] SYNC_RESET = 5'h0D;
  localparam logic [4:0] SYNC_NONE = 5'h00;
  localparam logic [2:0] TSEL_SYSCLK = 3'h7;
  localparam logic [2:0] TSEL_LAST_TIMER = 3'h4;
  localparam logic [1:0] PRESC_FOUR = 2'h3;
  localparam logic [3:0] PRESC_SIXTEEN = 4'hF;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [2:0] {
    ICDT_OFF = 3'b000,
    ICDT_EVERY_EDGE = 3'b001,
    ICDT_FALL = 3'b010,
    ICDT_RISE = 3'b011,
    ICDT_RISE_4 = 3'b100,
    ICDT_RISE_16 = 3'b101,
    ICDT_UNUSED = 3'b110,
    ICDT_WAKE_IRQ = 3'b111
  } icdt_mode_e;
  typedef enum logic [1:0] {
    ICDT_FREE = 2'b00,
    ICDT_SYNC = 2'b01,
    ICDT_TRIG = 2'b10,
    ICDT_SWTRIG = 2'b11
  } icdt_run_e;
  typedef struct packed {
    logic halt_in_idle;
    logic [2:0] timebase_select;
    logic [1:0] captures_per_interrupt;
    icdt_mode_e capture_mode_select;
  } icdt_ctrl_one_s;
  typedef struct packed {
    logic cascade_enable;
    logic trigger_mode_select;
    logic [4:0] sync_source_select;
  } icdt_ctrl_two_s;
endpackage : icdt_pkg

// >>> verilog/icdt_channel.sv
// input capture channel with dedicated 16-bit counter and apb registers
// What this block does
// - free-running counter increments on selected clock, wraps ffff to 0000
// - each capture pushes present counter value into four-entry fifo unless it is full
// - synchronous mode runs at once, sync event clears counter
// - trigger mode holds counter stopped until selected source fires
// - source zero, trigger clear is free-run; nonzero picks trigger or sync
// - source zero with trigger set is software trigger mode
// - cascaded: odd is low word, its rollover increments even counter
// - cascade bit set in both channels forms 32 bits, even first
// - cascaded even channel with trigger clear locks to odd channel
// - cascaded synchronous pair held in reset until sync source enabled
// - odd channel fields govern pair; odd buffer low, even buffer high
// - read-only not-empty flag follows fifo, clears when drained
// - halt-in-idle bit stops channel while cpu idles
// - timebase select: 111 system clock, 000-100 timers, others reserved
// - captures per interrupt field 00..11 means one to four; mode 001 ignores it and interrupts on every capture
// - modes 011 rise, 010 fall, 001 every edge, 000 off, 110 disabled
// - mode 100 every fourth rise, 101 every sixteenth rise
// - mode 111 is rising-edge wake interrupt only in sleep or idle
// - five-bit sync source resets to 01101; 00000 means none
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module icdt_channel #(
  parameter int WIDTH = 16,
  parameter int DEPTH = icdt_pkg::FIFO_DEPTH,
  parameter int NUM_TIMERS = 5,
  parameter int NUM_SOURCES = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input,
  input wire logic [NUM_TIMERS-1:0] timer_tick,
  input wire logic [NUM_SOURCES-1:0] sync_event,
  input wire logic sync_source_enabled,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic is_even_channel,
  input wire logic partner_rollover,
  input wire logic partner_sync_clear,
  input wire logic partner_capture,
  output logic rollover_out,
  output logic sync_clear_out,
  output logic capture_out,
  output logic [WIDTH-1:0] capture_counter,
  output logic capture_irq
);
  // synchroniser for the pin
  logic cap_meta_r;
  logic cap_sync_r;
  logic cap_prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_meta_r <= 1'b0;
      cap_sync_r <= 1'b0;
      cap_prev_r <= 1'b0;
    end else begin
      cap_meta_r <= capture_input;
      cap_sync_r <= cap_meta_r;
      cap_prev_r <= cap_sync_r;
    end
  end
  wire logic rise = cap_sync_r & ~cap_prev_r;
  wire logic fall = ~cap_sync_r & cap_prev_r;

  icdt_pkg::icdt_ctrl_one_s c1_r;
  icdt_pkg::icdt_ctrl_two_s c2_r;
  logic trig_run_r;
  logic ovr_r;
  logic [WIDTH-1:0] fifo_mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr_r;
  logic [$clog2(DEPTH)-1:0] rd_ptr_r;
  logic [$clog2(DEPTH):0] count_r;
  logic [WIDTH-1:0] cnt_r;
  logic [3:0] presc_r;
  logic [1:0] irq_cnt_r;

  // bus strobes: one wait state, every access completes in its second access cycle
  wire logic acc = psel & penable;
  // first access cycle only: a request held into the pready cycle must not
  // write or pop a second time
  wire logic wr = acc & ~pready & pwrite;
  wire logic fifo_rd = acc & ~pready & ~pwrite &
    (paddr == icdt_pkg::ADDR_FIFO_READ);
  wire logic mapped = (paddr == icdt_pkg::ADDR_CTRL_ONE) ||
    (paddr == icdt_pkg::ADDR_CTRL_TWO) ||
    (paddr == icdt_pkg::ADDR_FIFO_READ) ||
    (paddr == icdt_pkg::ADDR_STATUS);

  // mode decode
  wire logic src_zero = (c2_r.sync_source_select == icdt_pkg::SYNC_NONE);
  icdt_pkg::icdt_run_e run_mode;
  always_comb begin
    case ({src_zero, c2_r.trigger_mode_select})
      2'b10: run_mode = icdt_pkg::ICDT_FREE;
      2'b11: run_mode = icdt_pkg::ICDT_SWTRIG;
      2'b01: run_mode = icdt_pkg::ICDT_TRIG;
      2'b00: run_mode = icdt_pkg::ICDT_SYNC;
      default: run_mode = icdt_pkg::ICDT_FREE;
    endcase
  end
  // cascaded even channel with trigger clear follows the odd one
  wire logic slave = c2_r.cascade_enable & is_even_channel &
    ~c2_r.trigger_mode_select;
  wire logic sel_sync = sync_event[c2_r.sync_source_select];
  wire logic mode_on = (c1_r.capture_mode_select != icdt_pkg::ICDT_OFF) &&
    (c1_r.capture_mode_select != icdt_pkg::ICDT_UNUSED) &&
    (c1_r.capture_mode_select != icdt_pkg::ICDT_WAKE_IRQ);
  wire logic halted = c1_r.halt_in_idle & cpu_idle;
  // cascaded sync pair waits for its source to be switched on
  wire logic held = c2_r.cascade_enable && ~sync_source_enabled &&
    (slave || run_mode == icdt_pkg::ICDT_SYNC);
  wire logic trig_wait = ~slave && ~trig_run_r &&
    (run_mode == icdt_pkg::ICDT_TRIG ||
     run_mode == icdt_pkg::ICDT_SWTRIG);

  // timebase tick; reserved codes give no tick
  logic tick;
  always_comb begin
    if (c1_r.timebase_select == icdt_pkg::TSEL_SYSCLK)
      tick = 1'b1;
    else if (c1_r.timebase_select <= icdt_pkg::TSEL_LAST_TIMER)
      tick = timer_tick[c1_r.timebase_select];
    else
      tick = 1'b0;
  end

  // capture event, with prescaler for the every-nth modes
  logic cap_evt;
  always_comb begin
    case (c1_r.capture_mode_select)
      icdt_pkg::ICDT_RISE: cap_evt = rise;
      icdt_pkg::ICDT_FALL: cap_evt = fall;
      icdt_pkg::ICDT_EVERY_EDGE: cap_evt = rise | fall;
      icdt_pkg::ICDT_RISE_4:
        cap_evt = rise && (presc_r[1:0] == icdt_pkg::PRESC_FOUR);
      icdt_pkg::ICDT_RISE_16:
        cap_evt = rise && (presc_r == icdt_pkg::PRESC_SIXTEEN);
      default: cap_evt = 1'b0;
    endcase
    // no capture until the trigger has fired or software has started it
    if (halted || held || trig_wait) cap_evt = 1'b0;
    // the even half of a pair captures with the odd half so words match
    if (slave) cap_evt = partner_capture & ~halted;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) presc_r <= 4'h0;
    else if (!mode_on) presc_r <= 4'h0;
    else if (rise && !halted) presc_r <= presc_r + 4'h1;
  end

  // counter
  wire logic adv = slave ? partner_rollover : tick;
  wire logic clr_sync = slave ? partner_sync_clear :
    (run_mode == icdt_pkg::ICDT_SYNC && sel_sync);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= '0;
    else if (held || trig_wait) cnt_r <= '0;
    else if (clr_sync && !halted) cnt_r <= '0;
    else if (adv && !halted) cnt_r <= cnt_r + 1'b1;
  end
  wire logic roll = adv && !halted && !held && !trig_wait &&
    (cnt_r == '1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rollover_out <= 1'b0;
      sync_clear_out <= 1'b0;
      capture_out <= 1'b0;
      capture_counter <= '0;
    end else begin
      rollover_out <= roll;
      sync_clear_out <= clr_sync & ~halted;
      capture_out <= cap_evt;
      capture_counter <= cnt_r;
    end
  end

  // trigger flag: hardware set wins over software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trig_run_r <= 1'b0;
    else if (run_mode == icdt_pkg::ICDT_TRIG && sel_sync)
      trig_run_r <= 1'b1;
    else if (wr && paddr == icdt_pkg::ADDR_CTRL_TWO)
      trig_run_r <= pwdata[icdt_pkg::TRIG_RUN_BIT];
  end

  // fifo
  wire logic full = (count_r == ($clog2(DEPTH)+1)'(DEPTH));
  wire logic empty = (count_r == '0);
  wire logic push = cap_evt & ~full;
  wire logic pop = fifo_rd & ~empty;
  always_ff @(posedge pclk) begin
    if (push) fifo_mem[wr_ptr_r] <= cnt_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + {{$clog2(DEPTH){1'b0}}, push} -
        {{$clog2(DEPTH){1'b0}}, pop};
    end
  end
  // overflow: capture into full fifo sets, a read clears; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ovr_r <= 1'b0;
    else if (cap_evt && full) ovr_r <= 1'b1;
    else if (pop) ovr_r <= 1'b0;
  end

  // interrupt counting
  wire logic [1:0] irq_lim = (c1_r.capture_mode_select ==
    icdt_pkg::ICDT_EVERY_EDGE) ? 2'b00 : c1_r.captures_per_interrupt;
  wire logic wake = (c1_r.capture_mode_select == icdt_pkg::ICDT_WAKE_IRQ) &&
    (cpu_sleep || cpu_idle) && rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_cnt_r <= 2'b00;
      capture_irq <= 1'b0;
    end else begin
      capture_irq <= wake;
      if (!mode_on) irq_cnt_r <= 2'b00;
      else if (cap_evt) begin
        if (irq_cnt_r == irq_lim) begin
          irq_cnt_r <= 2'b00;
          capture_irq <= 1'b1;
        end else
          irq_cnt_r <= irq_cnt_r + 2'b01;
      end
    end
  end

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_r <= '0;
      c2_r <= '{cascade_enable: 1'b0, trigger_mode_select: 1'b0,
                sync_source_select: icdt_pkg::SYNC_RESET};
    end else if (wr && paddr == icdt_pkg::ADDR_CTRL_ONE) begin
      c1_r.halt_in_idle <= pwdata[icdt_pkg::HALT_IDLE_BIT];
      c1_r.timebase_select <= pwdata[icdt_pkg::TSEL_LSB +: 3];
      c1_r.captures_per_interrupt <= pwdata[icdt_pkg::CPI_LSB +: 2];
      c1_r.capture_mode_select <=
        icdt_pkg::icdt_mode_e'(pwdata[icdt_pkg::MODE_LSB +: 3]);
    end else if (wr && paddr == icdt_pkg::ADDR_CTRL_TWO) begin
      c2_r.cascade_enable <= pwdata[icdt_pkg::CASCADE_BIT];
      c2_r.trigger_mode_select <= pwdata[icdt_pkg::TRIG_SEL_BIT];
      c2_r.sync_source_select <= pwdata[icdt_pkg::SYNC_LSB +: 5];
    end
  end

  // read mux and response
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      icdt_pkg::ADDR_CTRL_ONE: begin
        rd_nxt[icdt_pkg::HALT_IDLE_BIT] = c1_r.halt_in_idle;
        rd_nxt[icdt_pkg::TSEL_LSB +: 3] = c1_r.timebase_select;
        rd_nxt[icdt_pkg::CPI_LSB +: 2] = c1_r.captures_per_interrupt;
        rd_nxt[icdt_pkg::OVR_BIT] = ovr_r;
        rd_nxt[icdt_pkg::BNE_BIT] = ~empty;
        rd_nxt[icdt_pkg::MODE_LSB +: 3] = c1_r.capture_mode_select;
      end
      icdt_pkg::ADDR_CTRL_TWO: begin
        rd_nxt[icdt_pkg::CASCADE_BIT] = c2_r.cascade_enable;
        rd_nxt[icdt_pkg::TRIG_SEL_BIT] = c2_r.trigger_mode_select;
        rd_nxt[icdt_pkg::TRIG_RUN_BIT] = trig_run_r;
        rd_nxt[icdt_pkg::SYNC_LSB +: 5] = c2_r.sync_source_select;
      end
      icdt_pkg::ADDR_FIFO_READ:
        // empty fifo reads zero rather than a stale entry
        rd_nxt[WIDTH-1:0] = empty ? '0 : fifo_mem[rd_ptr_r];
      icdt_pkg::ADDR_STATUS: rd_nxt[WIDTH-1:0] = cnt_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // registered answer: one wait state, ready in second access cycle
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata <= (acc && !pready && !pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end
endmodule : icdt_channel
`default_nettype wire

// >>> verif/icdt_checker.sv
// checker: port-level assertions on the capture channel
`timescale 1ns/100ps
`default_nettype none
module icdt_checker #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic [WIDTH-1:0] capture_counter,
  input wire logic capture_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic halt_r;
  icdt_pkg::icdt_mode_e mode_r;
  // shadow of control one, taken on the same edge as the design's write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_r <= 1'b0;
      mode_r <= icdt_pkg::ICDT_OFF;
    end else if (psel && penable && !pready && pwrite &&
                 paddr == icdt_pkg::ADDR_CTRL_ONE) begin
      halt_r <= pwdata[icdt_pkg::HALT_IDLE_BIT];
      mode_r <= icdt_pkg::icdt_mode_e'(pwdata[2:0]);
    end
  end
  sequence s_access;
    psel && penable && !pready;
  endsequence
  // four cycles leave room for the one-cycle-late counter copy
  sequence s_idle_halt;
    (halt_r && cpu_idle) [*4];
  endsequence
  property p_ready_wait;
    s_access |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_unmapped;
    s_access ##0 (paddr > icdt_pkg::ADDR_STATUS) |=> pready && pslverr;
  endproperty
  property p_counter_step;
    $changed(capture_counter) |->
      capture_counter == $past(capture_counter) + WIDTH'(1) ||
      capture_counter == '0;
  endproperty
  property p_idle_hold;
    s_idle_halt |-> $stable(capture_counter);
  endproperty
  property p_off_quiet;
    (mode_r == icdt_pkg::ICDT_OFF || mode_r == icdt_pkg::ICDT_UNUSED) [*4]
      |-> !capture_irq;
  endproperty
  property p_wake_awake;
    (mode_r == icdt_pkg::ICDT_WAKE_IRQ && !cpu_idle && !cpu_sleep) [*4]
      |-> !capture_irq;
  endproperty
  property p_irq_pulse;
    capture_irq |=> !capture_irq;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("pready missing after access cycle");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held two cycles");
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access without error");
  a_counter_step: assert property (p_counter_step)
    else $error("counter moved other than by one or to zero");
  a_idle_hold: assert property (p_idle_hold)
    else $error("counter ran while halted in idle");
  a_off_quiet: assert property (p_off_quiet)
    else $error("interrupt while channel disabled");
  a_wake_awake: assert property (p_wake_awake)
    else $error("wake interrupt while cpu awake");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than one cycle");
endmodule : icdt_checker
bind icdt_channel icdt_checker #(.WIDTH(WIDTH)) i_icdt_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
  .capture_counter(capture_counter), .capture_irq(capture_irq)
);
`default_nettype wire

// >>> verif/icdt_partner.sv
// far side model: capture pin pulses, timer ticks, sync source pulses
`timescale 1ns/100ps
`default_nettype none
module icdt_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pulse_go,
  input wire logic sync_go,
  input wire logic [4:0] sync_code,
  output logic capture_input,
  output logic [4:0] timer_tick,
  output logic [31:0] sync_event
);
  logic [2:0] width_r;
  logic tick_r;
  // four cycles high so the two-flop synchroniser sees both edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) width_r <= 3'h0;
    else if (pulse_go) width_r <= 3'h4;
    else if (width_r != 3'h0) width_r <= width_r - 3'h1;
  end
  assign capture_input = (width_r != 3'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_r <= 1'b0;
    else tick_r <= !tick_r;
  end
  assign timer_tick = {5{tick_r}};
  // callers pick output compare codes only, never a comparator or self
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sync_event <= 32'h0000_0000;
    else sync_event <= sync_go ? (32'h0000_0001 << sync_code) : 32'h0000_0000;
  end
endmodule : icdt_partner
`default_nettype wire

// >>> verif/icdt_channel_tb_top.sv
// testbench: apb sequences against the capture channel
`timescale 1ns/100ps
`default_nettype none
module icdt_channel_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic cpu_idle = 1'b0;
  logic cpu_sleep = 1'b0;
  logic sync_on = 1'b1;
  logic pulse_go = 1'b0;
  logic sync_go = 1'b0;
  logic [31:0] prdata, sync_event, r, v;
  logic pready, pslverr, capture_input, capture_irq, e;
  logic rollover_out, sync_clear_out, capture_out;
  logic [4:0] timer_tick;
  logic [15:0] capture_counter;
  int mismatches = 0;
  int comparisons = 0;
  int irqs = 0;
  int caps = 0;
  int syncs = 0;
  int rolls = 0;
  logic [2:0] mode_t [9] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h6, 3'h7, 3'h7};
  int cnt_t [9] = '{1, 1, 1, 4, 16, 1, 1, 1, 1};
  int exp_t [9] = '{2, 1, 1, 1, 1, 0, 0, 0, 1};
  logic idle_t [9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (capture_irq === 1'b1) irqs <= irqs + 1;
  always @(posedge pclk) if (capture_out === 1'b1) caps <= caps + 1;
  always @(posedge pclk) if (sync_clear_out === 1'b1) syncs <= syncs + 1;
  always @(posedge pclk) if (rollover_out === 1'b1) rolls <= rolls + 1;
  icdt_channel i_icdt_channel (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input(capture_input), .timer_tick(timer_tick),
    .sync_event(sync_event), .sync_source_enabled(sync_on),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .is_even_channel(1'b0),
    .partner_rollover(1'b0), .partner_sync_clear(1'b0),
    .partner_capture(1'b0), .rollover_out(rollover_out),
    .sync_clear_out(sync_clear_out),
    .capture_out(capture_out), .capture_counter(capture_counter),
    .capture_irq(capture_irq));
  icdt_partner i_icdt_partner (.pclk(pclk), .presetn(presetn),
    .pulse_go(pulse_go), .sync_go(sync_go), .sync_code(5'h01),
    .capture_input(capture_input), .timer_tick(timer_tick),
    .sync_event(sync_event));
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    rd(a);
    chk(nm, x, r & m);
  endtask : rdc
  task automatic cfg(input logic h, input logic [1:0] c, input logic [2:0] m);
    apb(1'b1, icdt_pkg::ADDR_CTRL_ONE,
        {18'h0_0000, h, icdt_pkg::TSEL_SYSCLK, 3'h0, c, 2'h0, m});
  endtask : cfg
  // pin pulses twelve cycles apart, then time for the synchroniser
  task automatic pulses(input int k);
    repeat (k) begin
      pulse_go <= 1'b1;
      @(posedge pclk);
      pulse_go <= 1'b0;
      repeat (11) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask : pulses
  task automatic fire_sync;
    sync_go <= 1'b1;
    @(posedge pclk);
    sync_go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : fire_sync
  initial begin
    // covers one full counter wrap plus the register tests
    repeat (90000) @(posedge pclk);
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ctrl_one", icdt_pkg::ADDR_CTRL_ONE, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc("ctrl_two", icdt_pkg::ADDR_CTRL_TWO, 32'hFFFF_FFFF, 32'h0000_000D);
    rdc("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, e});
    apb(1'b1, icdt_pkg::ADDR_CTRL_TWO, 32'h0000_0000);
    cfg(1'b0, 2'h3, icdt_pkg::ICDT_RISE);
    rd(icdt_pkg::ADDR_STATUS);
    v = r;
    rdc("count_step", icdt_pkg::ADDR_STATUS, 32'hFFFF_FFFF, v + 32'h0000_0004);
    irqs = 0;
    pulses(4);
    chk("irq_every_four", 32'h0000_0001, irqs);
    pulses(1);
    chk("capture_out", 32'h0000_0005, caps);
    rdc("ovr_bne", icdt_pkg::ADDR_CTRL_ONE, 32'h0000_0018, 32'h0000_0018);
    rd(icdt_pkg::ADDR_FIFO_READ);
    v = r;
    repeat (3) begin
      rd(icdt_pkg::ADDR_FIFO_READ);
      chk("capture_gap", 32'h0000_000C, r - v);
      v = r;
    end
    rdc("bne_clear", icdt_pkg::ADDR_CTRL_ONE, 32'h0000_0018, 32'h0000_0000);
    rdc("fifo_empty", icdt_pkg::ADDR_FIFO_READ, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      cfg(1'b0, 2'h0, icdt_pkg::ICDT_OFF);
      cfg(1'b0, 2'h0, mode_t[i]);
      cpu_idle <= idle_t[i];
      irqs = 0;
      pulses(cnt_t[i]);
      chk("mode_irqs", exp_t[i], irqs);
      repeat (4) rd(icdt_pkg::ADDR_FIFO_READ);
    end
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    irqs = 0;
    pulses(1);
    chk("sleep_wake", 32'h0000_0001, irqs);
    cpu_sleep <= 1'b0;
    cpu_idle <= 1'b1;
    cfg(1'b1, 2'h0, icdt_pkg::ICDT_RISE);
    repeat (4) @(posedge pclk);
    rd(icdt_pkg::ADDR_STATUS);
    v = r;
    repeat (20) @(posedge pclk);
    rdc("idle_hold", icdt_pkg::ADDR_STATUS, 32'hFFFF_FFFF, v);
    cpu_idle <= 1'b0;
    rd(icdt_pkg::ADDR_STATUS);
    chk("idle_run", 32'h0000_0001, {31'h0, r !== v});
    apb(1'b1, icdt_pkg::ADDR_CTRL_TWO, 32'h0000_0080);
    repeat (4) @(posedge pclk);
    rdc("held_zero", icdt_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, icdt_pkg::ADDR_CTRL_TWO, 32'h0000_00C0);
    rdc("sw_trig", icdt_pkg::ADDR_CTRL_TWO, 32'h0000_00C0, 32'h0000_00C0);
    rd(icdt_pkg::ADDR_STATUS);
    chk("sw_run", 32'h0000_0001, {31'h0, r !== 32'h0000_0000});
    apb(1'b1, icdt_pkg::ADDR_CTRL_TWO, 32'h0000_0081);
    repeat (4) @(posedge pclk);
    rdc("trig_wait", icdt_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    fire_sync;
    rdc("trig_flag", icdt_pkg::ADDR_CTRL_TWO, 32'h0000_00C1, 32'h0000_00C1);
    rd(icdt_pkg::ADDR_STATUS);
    chk("trig_run", 32'h0000_0001, {31'h0, r !== 32'h0000_0000});
    sync_on <= 1'b0;
    apb(1'b1, icdt_pkg::ADDR_CTRL_TWO, 32'h0000_0001);
    sync_on <= 1'b1;
    repeat (40) @(posedge pclk);
    fire_sync;
    rd(icdt_pkg::ADDR_STATUS);
    chk("sync_clear", 32'h0000_0001, {31'h0, r < 32'h0000_0010});
    chk("sync_out", 32'h0000_0001, syncs);
    // one full wrap of the counter on the system clock: exactly one rollover
    repeat (65540) @(posedge pclk);
    chk("rollover_out", 32'h0000_0001, rolls);
    end_sim;
  end
endmodule : icdt_channel_tb_top
`default_nettype wire
